// file: fcs_cfg.svh
// What this block does
// - Status read: bits 7,6,5,3 carry flags.
// - Erase gives FFh; program only clears bits.
// - Program polling reads inverse of data bit7.
// - Erase polling reads zero, any erasing sector.
// - Toggle flag inverts each monitored read while busy.
// - Fail on program timeout or zero-to-one.
// - Erase failure flag signals erase timeout.
// - Ready/busy pin shows completion.
// - Unlock pair then 20h enters bypass.
// - Bypass program: A0h then address/data.
// - Bypass accepts only program and exit.
// - Bypass exit: 90h then 00h, any address.
// - Bulk erase six writes; wrong write aborts.
// - Bulk zeroes all then erases; attempts limited.
// - Bulk erase ignores all instruction writes.
// - Extra sector codes within window join, restart.
// - Window flag zero counting, one erasing.
// - Window aborts on others; erase takes reset/suspend.
// - Suspend B0h with select high, ends window.
// - Toggle stops 0.1-15us after suspend.
// - Suspended: erasing sector invalid, no programming.
// - Resume is 30h with select high.
// - Unlock writes: AAh@555h then 55h@AAAh.
// - Reset aborts sector erase and window, ignored otherwise busy.
//
// Purpose: Constants for the flash command/status sequencer
// Assumes: 12-bit instruction address decode, byte-wide data
// Notes:   Times are in ns; window and suspend cycle counts derive from FCS_CLK_NS
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_UNLK1_ADDR   12'h555
`define FCS_UNLK1_DATA   8'hAA
`define FCS_UNLK2_ADDR   12'hAAA
`define FCS_UNLK2_DATA   8'h55
`define FCS_CMD_BYPASS   8'h20
`define FCS_CMD_PROG     8'hA0
`define FCS_CMD_EXIT1    8'h90
`define FCS_CMD_EXIT2    8'h00
`define FCS_CMD_ERASE    8'h80
`define FCS_CMD_BULK     8'h10
`define FCS_CMD_SECTOR   8'h30
`define FCS_CMD_RESUME   8'h30
`define FCS_CMD_SUSPEND  8'hB0
`define FCS_CMD_RESET    8'hF0
`define FCS_ERASED       8'hFF
`define FCS_ZEROED       8'h00
`define FCS_BIT_POLL     7
`define FCS_BIT_TOGGLE   6
`define FCS_BIT_FAIL     5
`define FCS_BIT_WIN      3
`define FCS_CLK_NS       4
`define FCS_WIN_NS       100000
`define FCS_SUSP_MIN_NS  100
`define FCS_SUSP_MAX_NS  15000
`define FCS_PROG_CYCLES  16
`define FCS_PROG_LIMIT   64
`define FCS_ERASE_LIMIT  100000
`endif

// file: fcs_mcu_model.sv
// Purpose: Core bus master model
// Assumes: One-cycle strobes, data the cycle after a read
// Notes:   Released data lines invert, stale values never pass
`timescale 1ns/100ps
module fcs_mcu_model (
    input  wire logic        clk,
    input  wire logic [7:0]  bus_rdata,
    output logic      [11:0] bus_addr,
    output logic      [7:0]  bus_wdata,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic      [7:0]  sel
);
    initial {bus_addr, bus_wdata, bus_wr, bus_rd, sel} = '0;
    // Write held until the sampling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] s);
        @(posedge clk);
        {bus_addr, bus_wdata, bus_wr, sel} <= {a, d, 1'b1, s};
        @(posedge clk);
        {bus_wdata, bus_wr, sel} <= {~d, 1'b0, 8'h00};
    endtask : wr
    // Read, data taken at the edge that ends its answer cycle
    task automatic rd(input logic [11:0] a, input logic [7:0] s, output logic [7:0] q);
        @(posedge clk);
        {bus_addr, bus_rd, sel} <= {a, 1'b1, s};
        @(posedge clk);
        {bus_rd, sel} <= {1'b0, 8'h00};
        @(posedge clk);
        q = bus_rdata;
    endtask : rd
    // Two reads with no gap, as a polling loop would issue them
    task automatic rd2(input logic [11:0] a, input logic [7:0] s,
                       output logic [7:0] q, output logic [7:0] q2);
        @(posedge clk);
        {bus_addr, bus_rd, sel} <= {a, 1'b1, s};
        repeat (2) @(posedge clk);
        q = bus_rdata;
        {bus_rd, sel} <= {1'b0, 8'h00};
        @(posedge clk);
        q2 = bus_rdata;
    endtask : rd2
    // Two writes with no gap, selects low
    task automatic wr2(input logic [11:0] a1, input logic [7:0] d1,
                       input logic [11:0] a2, input logic [7:0] d2);
        @(posedge clk);
        {bus_addr, bus_wdata, bus_wr, sel} <= {a1, d1, 1'b1, 8'h00};
        @(posedge clk);
        {bus_addr, bus_wdata} <= {a2, d2};
        @(posedge clk);
        {bus_wdata, bus_wr} <= {~d2, 1'b0};
    endtask : wr2
endmodule : fcs_mcu_model

// file: fcs_pkg.sv
// Purpose: Types for the flash command/status sequencer
// Assumes: Used with fcs_cfg.svh constants
// Notes:   State codes written out for waveform reading
package fcs_pkg;
    typedef enum logic [4:0] {
        ST_READ      = 5'h00,
        ST_UNLK1     = 5'h01,
        ST_UNLK2     = 5'h02,
        ST_CMD80     = 5'h03,
        ST_E_UNLK1   = 5'h04,
        ST_E_UNLK2   = 5'h05,
        ST_PROG_ADDR = 5'h06,
        ST_BYPASS    = 5'h07,
        ST_BYP_PROG  = 5'h08,
        ST_BYP_EXIT  = 5'h09,
        ST_PROGRAM   = 5'h0A,
        ST_BULK      = 5'h0B,
        ST_SEC_WIN   = 5'h0C,
        ST_SEC_ERASE = 5'h0D,
        ST_SUSP_WAIT = 5'h0E,
        ST_SUSPENDED = 5'h0F,
        ST_ERROR     = 5'h10
    } fcs_state_t;
endpackage : fcs_pkg

// file: fcs_sequencer.sv
// Purpose: Instruction decoder and embedded program/erase engine
// Assumes: Bus inputs synchronous to clk; selects are one-hot per access
// Notes:   Array contents are not reset; erase before first use
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "fcs_cfg.svh"

module fcs_sequencer #(
    parameter int SEC_BYTES   = 16,
    parameter int CNT_W       = 24,
    parameter int WIN_CYCLES  = `FCS_WIN_NS / `FCS_CLK_NS,
    parameter int PROG_CYCLES = `FCS_PROG_CYCLES,
    parameter int PROG_LIMIT  = `FCS_PROG_LIMIT,
    parameter int ERASE_LIMIT = `FCS_ERASE_LIMIT
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  primary_sector_selects,
    input  wire logic [3:0]  secondary_sector_selects,
    output logic      [7:0]  bus_rdata,
    output logic             ready_busy_pin
);
    localparam int NSEC        = 12;
    localparam int OFS_W       = $clog2(SEC_BYTES);
    localparam int IDX_W       = 4 + OFS_W;
    localparam int DEPTH       = NSEC * SEC_BYTES;
    localparam int SUSP_CYCLES = (`FCS_SUSP_MIN_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS;
    localparam int SUSP_MAX    = `FCS_SUSP_MAX_NS / `FCS_CLK_NS;

    // Refuse shapes the address split and counter cannot serve
    if (SEC_BYTES < 2 || SEC_BYTES > 4096 || (SEC_BYTES & (SEC_BYTES - 1)) != 0)
    begin : g_bad_sec
        $error("SEC_BYTES must be a power of two from 2 to 4096");
    end
    if (WIN_CYCLES < 1 || PROG_CYCLES < 1 || PROG_LIMIT < 1 || ERASE_LIMIT < 1
        || CNT_W > 31 || WIN_CYCLES >= (1 << CNT_W) || ERASE_LIMIT >= (1 << CNT_W)
        || PROG_LIMIT >= (1 << CNT_W) || PROG_CYCLES >= (1 << CNT_W))
    begin : g_bad_cnt
        $error("Timing counts must be at least one and fit CNT_W");
    end
    if (SUSP_CYCLES > SUSP_MAX)
    begin : g_bad_susp
        $error("Suspend settle count exceeds its longest time");
    end

    // Highest asserted select wins, so secondary overlays primary
    function automatic logic [3:0] sel_index(input logic [11:0] s);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < NSEC; i++)
        begin
            if (s[i])
                r = 4'(i);
        end
        return r;
    endfunction : sel_index

    // Sector membership test for the erase mask
    function automatic logic mask_hit(input logic [11:0] m, input logic [3:0] sec);
        return (sec < 4'(NSEC)) && m[sec];
    endfunction : mask_hit

    fcs_pkg::fcs_state_t     state_reg;
    logic [11:0]             mask_reg;
    logic [IDX_W-1:0]        prog_idx_reg;
    logic [7:0]              prog_data_reg;
    logic                    prog_bad_reg;
    logic                    byp_reg;
    logic                    op_erase_reg;
    logic                    phase_reg;
    logic [IDX_W-1:0]        ptr_reg;
    logic [CNT_W-1:0]        cnt_reg;
    logic                    tog_reg;
    logic [7:0]              rd_data_reg;
    logic [CNT_W-1:0]        susp_age_reg;
    logic [7:0]              mem [0:DEPTH-1];

    logic [11:0]             sel;
    logic                    sel_any;
    logic [3:0]              bus_sec;
    logic [IDX_W-1:0]        bus_idx;
    logic [7:0]              cur_byte;
    logic [3:0]              ptr_sec;
    logic                    unl1;
    logic                    unl2;
    logic                    at_555;
    logic                    walk_last;
    logic                    prog_end;
    logic                    prog_tmo;
    logic                    erase_tmo;
    logic                    win_end;
    logic                    susp_end;
    logic                    busy;
    logic                    toggling;
    logic                    mon_hit;
    logic                    status_rd;
    logic [7:0]              stat_byte;
    logic                    prog_wr;
    logic                    erase_wr;
    logic [7:0]              erase_data;

    // Access decode and unlock recognition
    assign sel      = {secondary_sector_selects, primary_sector_selects};
    assign sel_any  = |sel;
    assign bus_sec  = sel_index(sel);
    assign bus_idx  = {bus_sec, bus_addr[OFS_W-1:0]};
    assign cur_byte = mem[bus_idx];
    assign ptr_sec  = ptr_reg[IDX_W-1:OFS_W];
    assign at_555   = (bus_addr == `FCS_UNLK1_ADDR);
    assign unl1     = at_555 && (bus_wdata == `FCS_UNLK1_DATA);
    assign unl2     = (bus_addr == `FCS_UNLK2_ADDR) && (bus_wdata == `FCS_UNLK2_DATA);

    // Terminal counts: walk end from the pointer; timers share one counter, cleared on entry to a timed state
    assign walk_last = (ptr_reg == IDX_W'(DEPTH - 1));
    assign prog_end  = (cnt_reg == CNT_W'(PROG_CYCLES - 1));
    assign prog_tmo  = (cnt_reg == CNT_W'(PROG_LIMIT - 1));
    assign erase_tmo = (cnt_reg == CNT_W'(ERASE_LIMIT - 1));
    assign win_end   = (cnt_reg == CNT_W'(WIN_CYCLES - 1));
    assign susp_end  = (cnt_reg == CNT_W'(SUSP_CYCLES - 1));

    // Busy classification drives the pin and the toggle
    assign busy = (state_reg == fcs_pkg::ST_PROGRAM) || (state_reg == fcs_pkg::ST_BULK)
               || (state_reg == fcs_pkg::ST_SEC_WIN) || (state_reg == fcs_pkg::ST_SEC_ERASE)
               || (state_reg == fcs_pkg::ST_SUSP_WAIT);
    assign toggling       = busy || (state_reg == fcs_pkg::ST_ERROR);
    assign ready_busy_pin = !busy;

    // Monitored location: programmed byte, or any byte of an erasing sector
    assign mon_hit = sel_any && (op_erase_reg ? mask_hit(mask_reg, bus_sec)
                                              : (bus_idx == prog_idx_reg));
    // Suspended erasing sectors give status, not array data
    assign status_rd = (toggling || (state_reg == fcs_pkg::ST_SUSPENDED)) && mon_hit;

    // Status byte, don't-care bits driven low
    always_comb
    begin
        stat_byte = 8'h00;
        stat_byte[`FCS_BIT_POLL]   = op_erase_reg ? 1'b0 : ~prog_data_reg[7];
        stat_byte[`FCS_BIT_TOGGLE] = tog_reg;
        stat_byte[`FCS_BIT_FAIL]   = (state_reg == fcs_pkg::ST_ERROR);
        stat_byte[`FCS_BIT_WIN]    = (state_reg != fcs_pkg::ST_SEC_WIN);
    end

    // Array write sources: program ANDs, erase walk fills
    assign prog_wr    = (state_reg == fcs_pkg::ST_PROGRAM) && prog_end && !prog_tmo
                     && !prog_bad_reg;
    assign erase_wr   = ((state_reg == fcs_pkg::ST_SEC_ERASE) && mask_hit(mask_reg, ptr_sec))
                     || (state_reg == fcs_pkg::ST_BULK);
    assign erase_data = ((state_reg == fcs_pkg::ST_BULK) && !phase_reg)
                      ? `FCS_ZEROED : `FCS_ERASED;

    // Command sequencer and embedded algorithm
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg     <= fcs_pkg::ST_READ;
            mask_reg      <= 12'h000;
            prog_idx_reg  <= '0;
            prog_data_reg <= 8'h00;
            prog_bad_reg  <= 1'b0;
            byp_reg       <= 1'b0;
            op_erase_reg  <= 1'b0;
            phase_reg     <= 1'b0;
            ptr_reg       <= '0;
            cnt_reg       <= '0;
        end
        else
        begin
            cnt_reg <= cnt_reg + CNT_W'(1);
            unique case (state_reg)
                fcs_pkg::ST_READ:
                    if (bus_wr && unl1)
                        state_reg <= fcs_pkg::ST_UNLK1;
                fcs_pkg::ST_UNLK1:
                    if (bus_wr)
                        state_reg <= unl2 ? fcs_pkg::ST_UNLK2 : fcs_pkg::ST_READ;
                fcs_pkg::ST_UNLK2:
                    if (bus_wr && at_555 && bus_wdata == `FCS_CMD_PROG)
                        state_reg <= fcs_pkg::ST_PROG_ADDR;
                    else if (bus_wr && at_555 && bus_wdata == `FCS_CMD_ERASE)
                        state_reg <= fcs_pkg::ST_CMD80;
                    else if (bus_wr && at_555 && bus_wdata == `FCS_CMD_BYPASS)
                        state_reg <= fcs_pkg::ST_BYPASS;
                    else if (bus_wr)
                        state_reg <= fcs_pkg::ST_READ;
                fcs_pkg::ST_CMD80:
                    if (bus_wr)
                        state_reg <= unl1 ? fcs_pkg::ST_E_UNLK1 : fcs_pkg::ST_READ;
                fcs_pkg::ST_E_UNLK1:
                    if (bus_wr)
                        state_reg <= unl2 ? fcs_pkg::ST_E_UNLK2 : fcs_pkg::ST_READ;
                fcs_pkg::ST_E_UNLK2:
                    if (bus_wr && at_555 && bus_wdata == `FCS_CMD_BULK)
                    begin
                        state_reg    <= fcs_pkg::ST_BULK;
                        mask_reg     <= 12'hFFF;
                        op_erase_reg <= 1'b1;
                        phase_reg    <= 1'b0;
                        ptr_reg      <= '0;
                        cnt_reg      <= '0;
                    end
                    else if (bus_wr && sel_any && bus_wdata == `FCS_CMD_SECTOR)
                    begin
                        state_reg    <= fcs_pkg::ST_SEC_WIN;
                        mask_reg     <= sel;
                        op_erase_reg <= 1'b1;
                        ptr_reg      <= '0;
                        cnt_reg      <= '0;
                    end
                    else if (bus_wr)
                        state_reg <= fcs_pkg::ST_READ;
                fcs_pkg::ST_BYPASS:
                    if (bus_wr && bus_wdata == `FCS_CMD_PROG)
                        state_reg <= fcs_pkg::ST_BYP_PROG;
                    else if (bus_wr && bus_wdata == `FCS_CMD_EXIT1)
                        state_reg <= fcs_pkg::ST_BYP_EXIT;
                fcs_pkg::ST_BYP_EXIT:
                    if (bus_wr)
                        state_reg <= (bus_wdata == `FCS_CMD_EXIT2) ? fcs_pkg::ST_READ
                                                                   : fcs_pkg::ST_BYPASS;
                fcs_pkg::ST_PROG_ADDR,
                fcs_pkg::ST_BYP_PROG:
                    if (bus_wr)
                    begin
                        // Zero-to-one attempt is caught against the stored byte
                        state_reg     <= fcs_pkg::ST_PROGRAM;
                        prog_idx_reg  <= bus_idx;
                        prog_data_reg <= bus_wdata;
                        prog_bad_reg  <= |(bus_wdata & ~cur_byte);
                        byp_reg       <= (state_reg == fcs_pkg::ST_BYP_PROG);
                        op_erase_reg  <= 1'b0;
                        cnt_reg       <= '0;
                    end
                fcs_pkg::ST_PROGRAM:
                    // Writes, reset included, are ignored until the byte is done
                    if (prog_tmo || (prog_end && prog_bad_reg))
                        state_reg <= fcs_pkg::ST_ERROR;
                    else if (prog_end)
                        state_reg <= byp_reg ? fcs_pkg::ST_BYPASS : fcs_pkg::ST_READ;
                fcs_pkg::ST_BULK:
                begin
                    // Zero pass then erase pass; no write is looked at
                    ptr_reg <= walk_last ? '0 : ptr_reg + IDX_W'(1);
                    if (erase_tmo)
                        state_reg <= fcs_pkg::ST_ERROR;
                    else if (walk_last && !phase_reg)
                        phase_reg <= 1'b1;
                    else if (walk_last)
                        state_reg <= fcs_pkg::ST_READ;
                end
                fcs_pkg::ST_SEC_WIN:
                    if (bus_wr && sel_any && bus_wdata == `FCS_CMD_SECTOR)
                    begin
                        mask_reg <= mask_reg | sel;
                        cnt_reg  <= '0;
                    end
                    else if (bus_wr && sel_any && bus_wdata == `FCS_CMD_SUSPEND)
                    begin
                        state_reg <= fcs_pkg::ST_SUSP_WAIT;
                        cnt_reg   <= '0;
                    end
                    else if (bus_wr)
                        state_reg <= fcs_pkg::ST_READ;
                    else if (win_end)
                    begin
                        state_reg <= fcs_pkg::ST_SEC_ERASE;
                        cnt_reg   <= '0;
                    end
                fcs_pkg::ST_SEC_ERASE:
                    if (bus_wr && bus_wdata == `FCS_CMD_RESET)
                        state_reg <= fcs_pkg::ST_READ;
                    else if (bus_wr && sel_any && bus_wdata == `FCS_CMD_SUSPEND)
                    begin
                        state_reg <= fcs_pkg::ST_SUSP_WAIT;
                        cnt_reg   <= '0;
                    end
                    else if (erase_tmo)
                        state_reg <= fcs_pkg::ST_ERROR;
                    else
                    begin
                        ptr_reg <= walk_last ? '0 : ptr_reg + IDX_W'(1);
                        if (walk_last)
                            state_reg <= fcs_pkg::ST_READ;
                    end
                fcs_pkg::ST_SUSP_WAIT:
                    if (susp_end)
                        state_reg <= fcs_pkg::ST_SUSPENDED;
                fcs_pkg::ST_SUSPENDED:
                    // Erase walk position is kept so resume carries on
                    if (bus_wr && sel_any && bus_wdata == `FCS_CMD_RESUME)
                    begin
                        state_reg <= fcs_pkg::ST_SEC_ERASE;
                        cnt_reg   <= '0;
                    end
                    else if (bus_wr && bus_wdata == `FCS_CMD_RESET)
                        state_reg <= fcs_pkg::ST_READ;
                fcs_pkg::ST_ERROR:
                    if (bus_wr && bus_wdata == `FCS_CMD_RESET)
                        state_reg <= fcs_pkg::ST_READ;
                default:
                    state_reg <= fcs_pkg::ST_READ;
            endcase
        end
    end

    // Array update; no reset, contents survive like flash
    always_ff @(posedge clk)
    begin
        if (prog_wr)
            mem[prog_idx_reg] <= mem[prog_idx_reg] & prog_data_reg;
        else if (erase_wr)
            mem[ptr_reg] <= erase_data;
    end

    // Toggle flips per monitored read while the algorithm runs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tog_reg <= 1'b0;
        else if (bus_rd && mon_hit && toggling)
            tog_reg <= ~tog_reg;
    end

    // Read data registered; held until the next read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data_reg <= 8'h00;
        else if (bus_rd)
            rd_data_reg <= status_rd ? stat_byte : cur_byte;
    end
    assign bus_rdata = rd_data_reg;

    // Settle age kept apart from the shared timer, so the check is independent
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            susp_age_reg <= '0;
        else
            susp_age_reg <= (state_reg == fcs_pkg::ST_SUSP_WAIT) ? susp_age_reg + CNT_W'(1) : '0;
    end

    a_bulk_deaf: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == fcs_pkg::ST_BULK && bus_wr && !walk_last && !erase_tmo)
        |=> (state_reg == fcs_pkg::ST_BULK))
        else $error("Bulk erase reacted to a write");

    a_erase_fills_ones: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == fcs_pkg::ST_SEC_ERASE && !bus_wr && !erase_tmo
         && mask_hit(mask_reg, ptr_sec))
        |=> (mem[$past(ptr_reg)] == `FCS_ERASED))
        else $error("Erased byte is not FFh");

    a_prog_poll_inv: assert property (@(posedge clk) disable iff (!rst_b)
        (bus_rd && state_reg == fcs_pkg::ST_PROGRAM && mon_hit)
        |=> (bus_rdata[7] == ~prog_data_reg[7]))
        else $error("Polling flag not inverse of data bit 7");

    a_erase_poll_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (bus_rd && op_erase_reg && busy && mon_hit) |=> (bus_rdata[7] == 1'b0))
        else $error("Polling flag not zero during erase");

    a_toggle_flips: assert property (@(posedge clk) disable iff (!rst_b)
        (bus_rd && mon_hit && toggling) ##1 (bus_rd && mon_hit && toggling)
        |=> (bus_rdata[6] != $past(bus_rdata[6])))
        else $error("Toggle flag did not invert");

    a_window_flag_low: assert property (@(posedge clk) disable iff (!rst_b)
        (bus_rd && state_reg == fcs_pkg::ST_SEC_WIN && mon_hit) |=> !bus_rdata[3])
        else $error("Window flag not zero while counting");

    a_bypass_exit: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == fcs_pkg::ST_BYPASS && bus_wr && bus_wdata == `FCS_CMD_EXIT1)
        ##1 (bus_wr && bus_wdata == `FCS_CMD_EXIT2) |=> (state_reg == fcs_pkg::ST_READ))
        else $error("Bypass exit did not return to read");

    a_bad_bit_fails: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == fcs_pkg::ST_PROG_ADDR && bus_wr && |(bus_wdata & ~cur_byte))
        |-> ##[2:300] (state_reg == fcs_pkg::ST_ERROR))
        else $error("Zero-to-one program did not fail");

    a_suspend_settle: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == fcs_pkg::ST_SUSP_WAIT)
        |=> (state_reg == ((susp_age_reg == CNT_W'(SUSP_CYCLES)) ? fcs_pkg::ST_SUSPENDED
                                                                  : fcs_pkg::ST_SUSP_WAIT)))
        else $error("Suspend settle time wrong");

    a_reset_aborts: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == fcs_pkg::ST_SEC_ERASE && bus_wr && bus_wdata == `FCS_CMD_RESET)
        |=> (state_reg == fcs_pkg::ST_READ) && ready_busy_pin)
        else $error("Reset did not abort sector erase");

    a_window_abort: assert property (@(posedge clk) disable iff (!rst_b)
        (state_reg == fcs_pkg::ST_SEC_WIN && bus_wr && bus_wdata != `FCS_CMD_SECTOR
         && bus_wdata != `FCS_CMD_SUSPEND) |=> (state_reg == fcs_pkg::ST_READ))
        else $error("Window did not abort on foreign write");

endmodule : fcs_sequencer

// file: fcs_sequencer_tb.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Array unknown until the bulk erase
// Notes:   Window and erase limit shortened for run time
`timescale 1ns/100ps
module fcs_sequencer_tb;
    logic        clk;
    logic        rst_b;
    logic [11:0] a;
    logic [7:0]  d;
    logic        w;
    logic        r;
    logic [7:0]  s;
    logic [7:0]  rdata;
    logic        rdy;
    logic [7:0]  q;
    logic [7:0]  q2;
    int          mismatches;
    int          compares;
    int          cycles;
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    fcs_mcu_model i_fcs_mcu_model (.clk(clk), .bus_rdata(rdata), .bus_addr(a),
        .bus_wdata(d), .bus_wr(w), .bus_rd(r), .sel(s));
    fcs_sequencer #(.WIN_CYCLES(40), .ERASE_LIMIT(1000)) i_fcs_sequencer (.clk(clk),
        .rst_b(rst_b), .bus_addr(a), .bus_wdata(d), .bus_wr(w), .bus_rd(r),
        .primary_sector_selects(s), .secondary_sector_selects(4'h0),
        .bus_rdata(rdata), .ready_busy_pin(rdy));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] x, input logic [7:0] y, input logic [7:0] z);
        i_fcs_mcu_model.wr(x, y, z);
    endtask : wr
    task automatic rd2;
        i_fcs_mcu_model.rd2(12'h003, 8'h01, q, q2);
    endtask : rd2
    task automatic unlk;
        wr(12'h555, 8'hAA, 8'h00);
        wr(12'hAAA, 8'h55, 8'h00);
    endtask : unlk
    task automatic erase6(input logic [7:0] c, input logic [7:0] z);
        unlk();
        wr(12'h555, 8'h80, 8'h00);
        unlk();
        wr(12'h555, c, z);
    endtask : erase6
    // Bounded wait for the ready level
    task automatic wait_rdy;
        #1;
        for (int i = 0; i < 1000 && rdy !== 1'b1; i++) @(posedge clk);
        chk({7'h00, rdy}, 8'h01);
    endtask : wait_rdy
    task automatic t_bulk;
        erase6(8'h10, 8'h00);
        wr(12'h555, 8'hF0, 8'h00);
        rd2();
        chk(q & 8'hA8, 8'h08);
        chk({7'h00, q[6] ^ q2[6]}, 8'h01);
        chk({7'h00, rdy}, 8'h00);
        wait_rdy();
        rd2();
        chk(q, 8'hFF);
    endtask : t_bulk
    task automatic t_prog;
        unlk();
        wr(12'h555, 8'hA0, 8'h00);
        wr(12'h003, 8'h5A, 8'h01);
        rd2();
        chk(q & 8'hA8, 8'h88);
        chk({7'h00, q[6] ^ q2[6]}, 8'h01);
        wait_rdy();
        rd2();
        chk(q2, 8'h5A);
        chk(q, q2);
        unlk();
        wr(12'h555, 8'hA0, 8'h00);
        wr(12'h003, 8'hA5, 8'h01);
        wait_rdy();
        rd2();
        chk(q & 8'h20, 8'h20);
        chk(q2 & 8'h20, 8'h20);
        wr(12'h000, 8'hF0, 8'h00);
        rd2();
        chk(q & 8'h20, 8'h00);
    endtask : t_prog
    task automatic t_byp;
        unlk();
        wr(12'h555, 8'h20, 8'h00);
        wr(12'h000, 8'hA0, 8'h00);
        wr(12'h005, 8'hC3, 8'h01);
        wait_rdy();
        i_fcs_mcu_model.wr2(12'h123, 8'h90, 12'h456, 8'h00);
        wr(12'h000, 8'hA0, 8'h00);
        wr(12'h006, 8'h12, 8'h01);
        i_fcs_mcu_model.rd(12'h005, 8'h01, q);
        i_fcs_mcu_model.rd(12'h006, 8'h01, q2);
        chk(q, 8'hC3);
        chk(q2, 8'hFF);
    endtask : t_byp
    task automatic t_sec;
        erase6(8'h30, 8'h01);
        wr(12'h000, 8'h30, 8'h02);
        rd2();
        chk(q & 8'h88, 8'h00);
        i_fcs_mcu_model.rd2(12'h003, 8'h02, q, q2);
        chk(q & 8'h88, 8'h00);
        wr(12'h000, 8'hB0, 8'h01);
        repeat (30) @(posedge clk);
        rd2();
        chk({7'h00, q[6] ^ q2[6] ^ rdy}, 8'h01);
        wr(12'h000, 8'h30, 8'h01);
        wait_rdy();
        i_fcs_mcu_model.rd(12'h005, 8'h01, q);
        chk(q, 8'hFF);
        erase6(8'h30, 8'h01);
        wr(12'h000, 8'h55, 8'h00);
        @(posedge clk) chk({7'h00, rdy}, 8'h01);
        erase6(8'h30, 8'h01);
        repeat (45) @(posedge clk);
        rd2();
        chk(q & 8'h88, 8'h08);
        wr(12'h000, 8'hF0, 8'h00);
        @(posedge clk) chk({7'h00, rdy}, 8'h01);
    endtask : t_sec
    task automatic report_and_stop;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    // Hang guard, far above the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    initial
    begin
        {rst_b, mismatches, compares, cycles} = '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_bulk();
        t_prog();
        t_byp();
        t_sec();
        report_and_stop();
    end
endmodule : fcs_sequencer_tb
